// ==== common/asq_pkg.sv ====
package asq_pkg;

    localparam int ADDR_W = 8;
    localparam int RES_W = 10;
    localparam int NCH = 16;
    localparam int CH_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SCAN0 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SCAN1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SINGLE1 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SAR_VAL = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_CMP_RES = 8'h20;
    // Result words sit at 0x40..0x7C, selected by paddr[7:6]
    localparam logic [1:0] DATA_SEL = 2'h1;

    // Field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_SCAN = 2;
    localparam int CTRL_DMA = 3;
    localparam int SCAN0_CONT = 0;
    localparam int SGL_CMP = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SCAN = 1;
    localparam int STAT_CH_LSB = 4;
    localparam int IRQ_SINGLE = 0;
    localparam int IRQ_SCAN = 1;
    localparam int IRQ_W = 2;

    // Channel group codes
    localparam logic [1:0] GRP_4 = 2'h0;
    localparam logic [1:0] GRP_8 = 2'h1;
    localparam logic [CH_W-1:0] LAST_4 = 4'h3;
    localparam logic [CH_W-1:0] LAST_8 = 4'h7;
    localparam logic [CH_W-1:0] LAST_16 = 4'hF;

    // Comparator settling time per trial bit
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 50;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC + SYNC_STAGES - 1);
    localparam logic [RES_W-1:0] SAR_MSB_TRIAL = 10'h200;
    localparam logic [3:0] BIT_IDX_MSB = 4'h9;

    typedef enum logic [1:0] {SAR_IDLE, SAR_SETTLE, SAR_DECIDE} asq_sar_st_e;
    typedef enum logic {SEQ_IDLE, SEQ_CONV} asq_seq_st_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } asq_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } asq_apb_rsp_s;

endpackage

// ==== rtl/asq_sar.sv ====
`timescale 1ns/1ns
`default_nettype none
module asq_sar import asq_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic cmp_only,
    input wire logic [RES_W-1:0] cmp_value,
    input wire logic comp_in,
    output logic busy,
    output logic done,
    output logic [RES_W-1:0] result,
    output logic cmp_bit,
    output logic [RES_W-1:0] dac_code
);

    typedef struct packed {
        asq_sar_st_e st;
        logic [1:0] sync;
        logic [3:0] bit_idx;
        logic [7:0] cnt;
        logic [RES_W-1:0] code;
        logic cmp_only;
        logic cmp;
        logic done;
    } asq_sar_state_s;

    asq_sar_state_s s_r;
    asq_sar_state_s s_nxt;
    logic [3:0] next_idx;
    logic comp_s;

    assign next_idx = s_r.bit_idx - 4'h1;
    assign comp_s = s_r.sync[1];

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        // Second stage alone reads the first
        s_nxt.sync = {s_r.sync[0], comp_in};
        case (s_r.st)
            SAR_IDLE: begin
                if (start) begin
                    s_nxt.cmp_only = cmp_only;
                    s_nxt.code = cmp_only ? cmp_value : SAR_MSB_TRIAL;
                    s_nxt.bit_idx = BIT_IDX_MSB;
                    s_nxt.cnt = SETTLE_LOAD;
                    s_nxt.st = SAR_SETTLE;
                end
            end
            SAR_SETTLE: begin
                // Wait covers settling plus the synchroniser delay
                if (s_r.cnt == 8'h00) begin
                    s_nxt.st = SAR_DECIDE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            SAR_DECIDE: begin
                if (s_r.cmp_only) begin
                    s_nxt.cmp = comp_s;
                    s_nxt.done = 1'b1;
                    s_nxt.st = SAR_IDLE;
                end else begin
                    if (!comp_s) begin
                        s_nxt.code[s_r.bit_idx] = 1'b0;
                    end
                    if (s_r.bit_idx == 4'h0) begin
                        s_nxt.done = 1'b1;
                        s_nxt.st = SAR_IDLE;
                    end else begin
                        s_nxt.bit_idx = next_idx;
                        s_nxt.code[next_idx] = 1'b1;
                        s_nxt.cnt = SETTLE_LOAD;
                        s_nxt.st = SAR_SETTLE;
                    end
                end
            end
            default: begin
                s_nxt.st = SAR_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.st != SAR_IDLE);
    assign done = s_r.done;
    assign result = s_r.code;
    assign cmp_bit = s_r.cmp;
    assign dac_code = s_r.code;

endmodule
`default_nettype wire

// ==== rtl/asq_top.sv ====
// How it works
// - Single mode works on one channel, doing one conversion or one compare, then stops.
// - A finished single operation raises the interrupt, or a DMA request on instance zero.
// - Scan mode converts a group of 4, 8 or 16 channels one after another.
// - Single-shot scan does one pass and stops after the last channel.
// - Continuous scan wraps to channel zero until software writes the stop bit.
// - A 4-channel scan converts inputs 0 to 3 in rising order.
// - An 8-channel scan covers 0 to 7 and a 16-channel scan 0 to 15, rising.
// - Each scan result lands in the result word of its own channel, every pass.
// - Each finished scan pass raises the interrupt, or a DMA request on instance zero.
// - Single mode uses the channel from the single configuration select field.
// - A single compare against the approximation value sets or clears that channel's bit.
`timescale 1ns/1ns
`default_nettype none
module asq_top import asq_pkg::*; #(
    parameter bit INSTANCE_ZERO = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire asq_apb_req_s apb_i,
    output asq_apb_rsp_s apb_o,
    input wire logic comp_in,
    output logic [CH_W-1:0] ch_sel,
    output logic [RES_W-1:0] dac_code,
    output logic irq,
    output logic dma_req
);

    typedef struct packed {
        asq_seq_st_e st;
        logic [CH_W-1:0] ch;
        logic run_scan;
        logic run_cont;
        logic run_cmp;
        logic stop_req;
        logic sar_start;
        logic ctrl_scan;
        logic ctrl_dma;
        logic scan_cont;
        logic [1:0] grp;
        logic [CH_W-1:0] sgl_ch;
        logic sgl_cmp;
        logic [RES_W-1:0] sar_val;
        logic [NCH-1:0] cmp_res;
        logic [NCH-1:0][RES_W-1:0] data;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic dma_req;
        asq_apb_rsp_s rsp;
    } asq_state_s;

    asq_state_s s_r;
    asq_state_s s_nxt;

    logic sar_busy;
    logic sar_done;
    logic [RES_W-1:0] sar_result;
    logic sar_cmp;
    logic [RES_W-1:0] sar_dac;
    logic setup;
    logic wr;
    logic start_wr;
    logic stop_wr;
    logic ev_single;
    logic ev_scan;
    logic dma_sel;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0] rd_data;
    logic rd_err;

    function automatic logic [CH_W-1:0] last_ch(input logic [1:0] grp);
        case (grp)
            GRP_4: last_ch = LAST_4;
            GRP_8: last_ch = LAST_8;
            default: last_ch = LAST_16;
        endcase
    endfunction

    function automatic logic is_data(input logic [ADDR_W-1:0] a);
        is_data = (a[7:6] == DATA_SEL) && (a[1:0] == 2'h0);
    endfunction

    assign setup = apb_i.psel && !apb_i.penable;
    assign wr = apb_i.psel && apb_i.penable && s_r.rsp.pready && apb_i.pwrite;
    assign dma_sel = s_r.ctrl_dma && INSTANCE_ZERO;

    // Read mux, evaluated in the setup cycle
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (is_data(apb_i.paddr)) begin
            rd_data = 32'(s_r.data[apb_i.paddr[5:2]]);
        end else begin
            case (apb_i.paddr)
                OFF_CTRL: begin
                    rd_data[CTRL_SCAN] = s_r.ctrl_scan;
                    rd_data[CTRL_DMA] = s_r.ctrl_dma;
                end
                OFF_SCAN0: rd_data[SCAN0_CONT] = s_r.scan_cont;
                OFF_SCAN1: rd_data = 32'(s_r.grp);
                OFF_SINGLE1: rd_data = 32'({s_r.sgl_cmp, s_r.sgl_ch});
                OFF_STATUS: begin
                    rd_data[STAT_BUSY] = (s_r.st != SEQ_IDLE);
                    rd_data[STAT_SCAN] = s_r.run_scan;
                    rd_data[STAT_CH_LSB +: CH_W] = s_r.ch;
                end
                OFF_IRQ_STAT: rd_data = 32'(s_r.irq_stat);
                OFF_IRQ_MASK: rd_data = 32'(s_r.irq_mask);
                OFF_SAR_VAL: rd_data = 32'(s_r.sar_val);
                OFF_CMP_RES: rd_data = 32'(s_r.cmp_res);
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.sar_start = 1'b0;
        s_nxt.dma_req = 1'b0;
        start_wr = 1'b0;
        stop_wr = 1'b0;
        irq_clr = '0;
        ev_single = 1'b0;
        ev_scan = 1'b0;
        // Zero-wait slave: pready rises in every access phase
        s_nxt.rsp.pready = setup;
        s_nxt.rsp.pslverr = setup && rd_err;
        s_nxt.rsp.prdata = (setup && !apb_i.pwrite) ? rd_data : 32'h0000_0000;
        if (wr && !rd_err) begin
            case (apb_i.paddr)
                OFF_CTRL: begin
                    start_wr = apb_i.pwdata[CTRL_START];
                    stop_wr = apb_i.pwdata[CTRL_STOP];
                    s_nxt.ctrl_scan = apb_i.pwdata[CTRL_SCAN];
                    s_nxt.ctrl_dma = apb_i.pwdata[CTRL_DMA];
                end
                // Scan type and channel group held in two registers
                // scan configuration
                OFF_SCAN0: s_nxt.scan_cont = apb_i.pwdata[SCAN0_CONT];
                OFF_SCAN1: s_nxt.grp = apb_i.pwdata[1:0];
                OFF_SINGLE1: begin
                    s_nxt.sgl_ch = apb_i.pwdata[CH_W-1:0];
                    s_nxt.sgl_cmp = apb_i.pwdata[SGL_CMP];
                end
                OFF_IRQ_STAT: irq_clr = apb_i.pwdata[IRQ_W-1:0];
                OFF_IRQ_MASK: s_nxt.irq_mask = apb_i.pwdata[IRQ_W-1:0];
                OFF_SAR_VAL: s_nxt.sar_val = apb_i.pwdata[RES_W-1:0];
                default: begin
                end
            endcase
        end
        if (stop_wr && s_r.st != SEQ_IDLE) begin
            s_nxt.stop_req = 1'b1;
        end
        case (s_r.st)
            SEQ_IDLE: begin
                s_nxt.stop_req = 1'b0;
                // Start while busy is ignored
                if (start_wr) begin
                    s_nxt.run_scan = s_nxt.ctrl_scan;
                    s_nxt.run_cont = s_nxt.scan_cont;
                    s_nxt.run_cmp = s_nxt.sgl_cmp && !s_nxt.ctrl_scan;
                    s_nxt.ch = s_nxt.ctrl_scan ? '0 : s_nxt.sgl_ch;
                    s_nxt.sar_start = 1'b1;
                    s_nxt.st = SEQ_CONV;
                end
            end
            SEQ_CONV: begin
                if (sar_done && !s_r.run_scan) begin
                    if (s_r.run_cmp) begin
                        s_nxt.cmp_res[s_r.ch] = sar_cmp;
                    end else begin
                        s_nxt.data[s_r.ch] = sar_result;
                    end
                    ev_single = 1'b1;
                    s_nxt.st = SEQ_IDLE;
                end else if (sar_done) begin
                    s_nxt.data[s_r.ch] = sar_result;
                    if (s_r.ch == last_ch(s_r.grp)) begin
                        ev_scan = 1'b1;
                        if (s_r.run_cont && !s_nxt.stop_req) begin
                            s_nxt.ch = '0;
                            s_nxt.sar_start = 1'b1;
                        end else begin
                            s_nxt.st = SEQ_IDLE;
                        end
                    end else if (s_nxt.stop_req) begin
                        // Stop ends a partial pass with no pass event
                        s_nxt.st = SEQ_IDLE;
                    end else begin
                        s_nxt.ch = s_r.ch + 4'h1;
                        s_nxt.sar_start = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.st = SEQ_IDLE;
            end
        endcase
        irq_set = dma_sel ? '0 : {ev_scan, ev_single};
        s_nxt.dma_req = dma_sel && (ev_single || ev_scan);
        // Set beats a simultaneous write-one clear
        s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    asq_sar u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(s_r.sar_start),
        .cmp_only(s_r.run_cmp),
        .cmp_value(s_r.sar_val),
        .comp_in(comp_in),
        .busy(sar_busy),
        .done(sar_done),
        .result(sar_result),
        .cmp_bit(sar_cmp),
        .dac_code(sar_dac)
    );

    assign apb_o = s_r.rsp;
    assign ch_sel = s_r.ch;
    assign dac_code = sar_dac;
    assign irq = s_r.irq;
    assign dma_req = s_r.dma_req;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_single_stops: assert property (
        (s_r.st == SEQ_CONV && !s_r.run_scan && sar_done)
        |=> (s_r.st == SEQ_IDLE) [*2])
        else $error("single mode did not stop");

    a_single_event: assert property (
        (s_r.st == SEQ_CONV && !s_r.run_scan && sar_done)
        |=> (dma_sel ? (dma_req && !$rose(s_r.irq_stat[IRQ_SINGLE]))
                     : s_r.irq_stat[IRQ_SINGLE]))
        else $error("single completion not signalled");

    a_scan_step: assert property (
        (s_r.st == SEQ_CONV && s_r.run_scan && sar_done && !s_nxt.stop_req
         && s_r.ch != last_ch(s_r.grp))
        |=> s_r.ch == $past(s_r.ch) + 4'h1 ##1 sar_busy)
        else $error("scan did not step to next channel");

    a_oneshot_end: assert property (
        (s_r.st == SEQ_CONV && s_r.run_scan && !s_r.run_cont && sar_done
         && s_r.ch == last_ch(s_r.grp))
        |=> s_r.st == SEQ_IDLE && !s_r.sar_start)
        else $error("single-shot scan did not stop");

    a_cont_wrap: assert property (
        (s_r.st == SEQ_CONV && s_r.run_scan && s_r.run_cont && sar_done
         && !s_nxt.stop_req && s_r.ch == last_ch(s_r.grp))
        |=> s_r.ch == '0 && s_r.sar_start ##1 sar_busy)
        else $error("continuous scan did not wrap");

    a_result_store: assert property (
        (s_r.st == SEQ_CONV && s_r.run_scan && sar_done)
        |=> s_r.data[$past(s_r.ch)] == $past(sar_result))
        else $error("scan result stored in wrong word");

    a_pass_event: assert property (
        (s_r.st == SEQ_CONV && s_r.run_scan && sar_done && !dma_sel
         && s_r.ch == last_ch(s_r.grp))
        |=> s_r.irq_stat[IRQ_SCAN] ##1 (irq == s_r.irq_mask[IRQ_SCAN]
            || s_r.irq_stat[IRQ_SINGLE]))
        else $error("scan pass completion not flagged");

    a_single_chan: assert property (
        (s_r.st == SEQ_IDLE && start_wr && !s_nxt.ctrl_scan)
        |=> s_r.ch == $past(s_nxt.sgl_ch) && s_r.sar_start)
        else $error("single mode took wrong channel");

    a_cmp_bit: assert property (
        (s_r.st == SEQ_CONV && s_r.run_cmp && sar_done)
        |=> s_r.cmp_res[$past(s_r.ch)] == $past(sar_cmp))
        else $error("compare bit not updated");

    a_hold_chan: assert property (
        (s_r.st == SEQ_CONV && !sar_done) |=> $stable(s_r.ch))
        else $error("channel changed before result stored");

    c_single_conv: cover property (
        s_r.st == SEQ_CONV && !s_r.run_scan && !s_r.run_cmp && sar_done);
    c_single_cmp: cover property (
        s_r.st == SEQ_CONV && s_r.run_cmp && sar_done);
    c_pass16: cover property (
        s_r.run_scan && sar_done && s_r.ch == LAST_16);
    c_cont_wrap: cover property (
        s_r.run_cont && sar_done && s_r.ch == last_ch(s_r.grp)
        ##1 s_r.ch == '0 && s_r.st == SEQ_CONV);

endmodule
`default_nettype wire

// ==== verification/asq_analog_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module asq_analog_model import asq_pkg::*; #(
    parameter int LAG_NS = 0
) (
    input wire logic [CH_W-1:0] ch_sel,
    input wire logic [RES_W-1:0] dac_code,
    input wire logic [NCH-1:0][RES_W-1:0] levels,
    output logic comp_in
);
    // Ideal comparator with a small lag, so a late answer is also exercised
    assign #LAG_NS comp_in = (levels[ch_sel] >= dac_code);
endmodule
`default_nettype wire

// ==== verification/tb_adc_scan_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_adc_scan_sequencer import asq_pkg::*;;
    localparam logic [32:0] FULL = 33'h0FFFFFFFF;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    asq_apb_req_s req = '0;
    asq_apb_rsp_s rsp;
    logic comp_in, irq, dma_req;
    logic [CH_W-1:0] ch_sel, last_ch, prev_ch;
    logic [RES_W-1:0] dac_code;
    logic [NCH-1:0][RES_W-1:0] lvl = '0;
    logic [15:0] seed = 16'h5A1A;
    logic [32:0] eq[$];
    logic [32:0] mq[$];
    logic [32:0] e, m;
    logic scan_on = 1'b0;
    logic first = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int nchg = 0;
    int ndma = 0;

    always #5 pclk = ~pclk;

    asq_top #(.INSTANCE_ZERO(1'b1)) i_dut (.pclk(pclk), .presetn(presetn),
        .apb_i(req), .apb_o(rsp), .comp_in(comp_in), .ch_sel(ch_sel),
        .dac_code(dac_code), .irq(irq), .dma_req(dma_req));

    asq_analog_model #(.LAG_NS(3)) i_ana (.ch_sel(ch_sel),
        .dac_code(dac_code), .levels(lvl), .comp_in(comp_in));

    function automatic logic [RES_W-1:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[RES_W-1:0];
    endfunction

    function automatic logic [7:0] dadr(input int c);
        return {DATA_SEL, c[3:0], 2'b00};
    endfunction

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Master holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) @(posedge pclk);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] x,
                      input logic [32:0] k);
        eq.push_back(x);
        mq.push_back(k);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic clr(input logic [31:0] v);
        wr(OFF_IRQ_STAT, v);
        repeat (2) @(posedge pclk);
        chk(33'(irq), 33'h0);
    endtask

    task automatic wait_irq();
        int i;
        for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge pclk);
        chk(33'(irq), 33'h1);
    endtask

    // Response checker: oldest note against each read answer
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 60000) begin
            failures++;
            stop_test();
        end
        if (req.psel && req.penable && !req.pwrite &&
            rsp.pready === 1'b1 && eq.size() > 0) begin
            e = eq.pop_front();
            m = mq.pop_front();
            chk({rsp.pslverr, rsp.prdata} & m, e & m);
        end
        if (dma_req === 1'b1)
            ndma++;
    end

    always @(ch_sel) begin
        if (scan_on) begin
            chk(33'(ch_sel), 33'(first ? 4'h0 :
                (prev_ch == last_ch ? 4'h0 : prev_ch + 4'h1)));
            first = 1'b0;
            prev_ch = ch_sel;
            nchg++;
        end
    end

    initial begin
        int g, c, n, k;
        for (c = 0; c < NCH; c++) lvl[c] = rnd();
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_STATUS, 33'h0, FULL);
        rd(OFF_IRQ_STAT, 33'h0, FULL);
        rd(8'h24, 33'h100000000, 33'h100000000);
        wr(OFF_IRQ_MASK, 32'h3);
        wr(OFF_SINGLE1, 32'h5);
        wr(OFF_CTRL, 32'h1);
        wait_irq();
        rd(dadr(5), 33'(lvl[5]), FULL);
        rd(OFF_IRQ_STAT, 33'h1, FULL);
        clr(32'h1);
        // Masked event keeps irq low until unmasked
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_SINGLE1, 32'h2);
        wr(OFF_CTRL, 32'h1);
        repeat (150) @(posedge pclk);
        chk(33'(irq), 33'h0);
        rd(OFF_IRQ_STAT, 33'h1, FULL);
        wr(OFF_IRQ_MASK, 32'h3);
        repeat (2) @(posedge pclk);
        chk(33'(irq), 33'h1);
        clr(32'h1);
        rd(dadr(2), 33'(lvl[2]), FULL);
        // Compare: set the bit, then clear it again
        wr(OFF_SAR_VAL, 32'h200);
        for (k = 0; k < 2; k++) begin
            lvl[3] = k == 0 ? 10'h3FF : 10'h000;
            wr(OFF_SINGLE1, 32'h13);
            wr(OFF_CTRL, 32'h1);
            wait_irq();
            clr(32'h1);
            rd(OFF_CMP_RES, 33'(k == 0 ? 4'h8 : 4'h0), 33'h8);
        end
        // DMA replaces the interrupt event on instance zero
        wr(OFF_SINGLE1, 32'h7);
        ndma = 0;
        wr(OFF_CTRL, 32'h9);
        repeat (150) @(posedge pclk);
        chk(33'(ndma), 33'h1);
        rd(OFF_IRQ_STAT, 33'h0, FULL);
        rd(dadr(7), 33'(lvl[7]), FULL);
        // Single-shot scans over every group code
        for (g = 0; g < 4; g++) begin
            n = g == 0 ? 4 : (g == 1 ? 8 : 16);
            last_ch = 4'(n - 1);
            for (c = 0; c < NCH; c++) lvl[c] = rnd();
            wr(OFF_SCAN0, 32'h0);
            wr(OFF_SCAN1, 32'(g));
            nchg = 0;
            first = 1'b1;
            scan_on = 1'b1;
            wr(OFF_CTRL, 32'h5);
            wait_irq();
            chk(33'(nchg), 33'(n));
            repeat (100) @(posedge pclk);
            chk(33'(nchg), 33'(n));
            scan_on = 1'b0;
            rd(OFF_STATUS, 33'h0, 33'h1);
            rd(OFF_IRQ_STAT, 33'h2, FULL);
            clr(32'h2);
            for (c = 0; c < n; c++)
                rd(dadr(c), 33'(lvl[c]), FULL);
        end
        // Continuous scan wraps, overwrites, then stops on request
        for (c = 0; c < NCH; c++) lvl[c] = rnd();
        wr(OFF_SCAN0, 32'h1);
        wr(OFF_SCAN1, 32'h1);
        last_ch = 4'h7;
        nchg = 0;
        first = 1'b1;
        scan_on = 1'b1;
        wr(OFF_CTRL, 32'h5);
        wait_irq();
        // Wrap to channel 0 lands on the same edge as the pass event
        chk(33'(nchg), 33'h9);
        clr(32'h2);
        lvl[7] = ~lvl[7];
        wait_irq();
        chk(33'(nchg), 33'h11);
        wr(OFF_CTRL, 32'h2);
        repeat (200) @(posedge pclk);
        rd(OFF_STATUS, 33'h0, 33'h1);
        k = nchg;
        repeat (200) @(posedge pclk);
        chk(33'(nchg), 33'(k));
        scan_on = 1'b0;
        rd(dadr(7), 33'(lvl[7]), FULL);
        repeat (2) @(posedge pclk);
        stop_test();
    end
endmodule
`default_nettype wire
